// File: core/asi_defs.vh
`ifndef ASI_DEFS_VH
`define ASI_DEFS_VH

// control byte layout, first one after select falls is the start bit
`define ASI_CTRL_BITS 8
`define ASI_CTRL_START 7
`define ASI_CTRL_SEL_HI 6
`define ASI_CTRL_SEL_LO 4
`define ASI_CTRL_POLARITY 3
`define ASI_CTRL_TOPOLOGY 2
`define ASI_CTRL_MODE_HI 1
`define ASI_CTRL_MODE_LO 0
// bit counts at which the sample path changes state
`define ASI_TRACK_AFTER_BIT 5
`define ASI_HOLD_AFTER_BIT 8

// clock/power mode codes
`define ASI_MODE_EXT_CLK 2'h3
`define ASI_MODE_INT_CLK 2'h2

// result width
`define ASI_RES_BITS 10

// timing
`define ASI_CLK_PERIOD_NS 10
`define ASI_INT_CONV_NS 10000

// register byte offsets
`define ASI_REG_CODE 4'h0
`define ASI_REG_STATUS 4'h4
`define ASI_REG_COUNT 4'h8
`define ASI_REG_CTRL_BYTE 4'hC

// reset values
`define ASI_CODE_RESET 10'h000
`define ASI_SYNC_RESET 5'h10

// status word fields
`define ASI_ST_BUSY 0
`define ASI_ST_TRACK 1
`define ASI_ST_HOLD 2
`define ASI_ST_EXT_MODE 3
`define ASI_ST_SHUTDOWN 4
`define ASI_ST_REF_INT 5
`define ASI_ST_CTRL_VALID 6

`endif

// File: core/asi_sync.v
`timescale 1ns/1ns
`default_nettype none
module asi_sync #(
  parameter W = 1,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  // clock and reset
  input wire clk,
  input wire arst_n,
  // asynchronous levels in, synchronised levels out
  input wire [W-1:0] d,
  output reg [W-1:0] q
);

  reg [W-1:0] meta_q;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule
`default_nettype wire

// File: core/asi_conv_timer.v
`timescale 1ns/1ns
`default_nettype none
module asi_conv_timer #(
  parameter CYCLES = 1000,
  parameter CW = 16
) (
  // clock and reset
  input wire clk,
  input wire arst_n,
  // control
  input wire start,
  input wire abort,
  // status
  output reg busy,
  output reg done
);

  reg [CW-1:0] cnt_q;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= {CW{1'b0}};
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (abort) begin
        busy <= 1'b0;
        cnt_q <= {CW{1'b0}};
      end else if (start) begin
        busy <= 1'b1;
        cnt_q <= CYCLES[CW-1:0] - {{(CW-1){1'b0}}, 1'b1};
      end else if (busy) begin
        if (cnt_q == {CW{1'b0}}) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt_q <= cnt_q - {{(CW-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule
`default_nettype wire

// File: core/asi_serial_strobe.v
// Contract
// - result output changes only on clock falls
// - result output released while select high
// - data input ignored unless select low
// - data sampled on serial clock rise
// - internal mode: strobe low during conversion
// - external mode: one-period strobe before MSB; after reset, shutdown or an internal conversion it is held high until MSB
// - external mode: strobe released while select high
// - external mode steps on host clock
// - powerdown pin low means full shutdown
// - high: internal compensation, mid: external
// - track after bit five, hold after eight
// - external conversion spans fifteen clocks; the logic takes one strobe period plus ten bit periods
//
// Added by the designer: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ns
`default_nettype none
`include "asi_defs.vh"
module asi_serial_strobe #(
  parameter RES_W = `ASI_RES_BITS,
  parameter INT_CONV_NS = `ASI_INT_CONV_NS
) (
  // system
  input wire CLK,
  input wire ARST_N,
  // register bus
  input wire [3:0] AVS_ADDRESS,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire [31:0] AVS_WRITEDATA,
  input wire [3:0] AVS_BYTEENABLE,
  output reg [31:0] AVS_READDATA,
  output reg AVS_WAITREQUEST,
  // serial link
  input wire CS_N,
  input wire SCLK,
  input wire DIN,
  output reg DOUT_O,
  output reg DOUT_OE_N,
  output reg CONVERSION_STROBE_OUT,
  output reg CONVERSION_STROBE_OUT_OE_N,
  // three-level powerdown comparators
  input wire THREE_LEVEL_POWERDOWN_IN_LO,
  input wire THREE_LEVEL_POWERDOWN_IN_HI,
  output reg SHUTDOWN_ACTIVE,
  output reg REF_INTERNAL_COMP
);

  localparam CONV_CYCLES = (INT_CONV_NS + `ASI_CLK_PERIOD_NS - 1) / `ASI_CLK_PERIOD_NS;
  localparam CAP_IDLE = 1'b0;
  localparam CAP_CTRL = 1'b1;
  localparam CV_IDLE = 2'd0;
  localparam CV_STRB = 2'd1;
  localparam CV_INT = 2'd2;
  localparam CV_SHIFT = 2'd3;

  // synchronised link and power pins
  wire [4:0] pin_s;
  wire cs_n_s;
  wire sclk_s;
  wire din_s;
  wire pd_lo_s;
  wire pd_hi_s;

  asi_sync #(
    .W(5),
    .RST_VAL(`ASI_SYNC_RESET)
  ) u_sync (
    .clk(CLK),
    .arst_n(ARST_N),
    .d({CS_N, SCLK, DIN, THREE_LEVEL_POWERDOWN_IN_LO, THREE_LEVEL_POWERDOWN_IN_HI}),
    .q(pin_s)
  );

  assign cs_n_s = pin_s[4];
  assign sclk_s = pin_s[3];
  assign din_s = pin_s[2];
  assign pd_lo_s = pin_s[1];
  assign pd_hi_s = pin_s[0];

  reg sclk_prev_q;
  wire sclk_rise;
  wire sclk_fall;
  wire link_on;

  assign sclk_rise = sclk_s & ~sclk_prev_q;
  assign sclk_fall = ~sclk_s & sclk_prev_q;
  assign link_on = ~cs_n_s & ~pd_lo_s;

  // control byte capture
  reg cap_q;
  reg [3:0] bit_cnt_q;
  reg [7:0] ctrl_sh_q;
  reg [7:0] ctrl_byte_q;
  reg ctrl_valid_q;
  reg hold_pend_q;
  reg track_q;
  reg hold_q;
  wire conv_go;
  wire [7:0] ctrl_next;

  assign ctrl_next = {ctrl_sh_q[6:0], din_s};
  // hold and conversion start share the fall, so the strobe spans a whole period
  assign conv_go = hold_pend_q & sclk_fall & ~cs_n_s & ~pd_lo_s;

  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sclk_prev_q <= 1'b0;
      cap_q <= CAP_IDLE;
      bit_cnt_q <= 4'h0;
      ctrl_sh_q <= 8'h00;
      ctrl_byte_q <= 8'h00;
      ctrl_valid_q <= 1'b0;
      hold_pend_q <= 1'b0;
      track_q <= 1'b0;
      hold_q <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_s;
      if (pd_lo_s) begin
        cap_q <= CAP_IDLE;
        bit_cnt_q <= 4'h0;
        hold_pend_q <= 1'b0;
        track_q <= 1'b0;
        hold_q <= 1'b0;
      end else if (cs_n_s) begin
        cap_q <= CAP_IDLE;
        bit_cnt_q <= 4'h0;
        hold_pend_q <= 1'b0;
        track_q <= 1'b0;
      end else begin
        if (sclk_rise) begin
          case (cap_q)
            CAP_IDLE: begin
              if (din_s) begin
                cap_q <= CAP_CTRL;
                ctrl_sh_q <= 8'h01;
                bit_cnt_q <= 4'h1;
              end
            end
            CAP_CTRL: begin
              ctrl_sh_q <= ctrl_next;
              bit_cnt_q <= bit_cnt_q + 4'h1;
              if (bit_cnt_q == `ASI_CTRL_BITS - 1) begin
                ctrl_byte_q <= ctrl_next;
                ctrl_valid_q <= 1'b1;
                hold_pend_q <= 1'b1;
                cap_q <= CAP_IDLE;
              end
            end
            default: cap_q <= CAP_IDLE;
          endcase
        end
        if (sclk_fall) begin
          if (cap_q == CAP_CTRL && bit_cnt_q == `ASI_TRACK_AFTER_BIT) begin
            track_q <= 1'b1;
            hold_q <= 1'b0;
          end
          if (hold_pend_q) begin
            hold_pend_q <= 1'b0;
            track_q <= 1'b0;
            hold_q <= 1'b1;
          end
        end
      end
    end
  end

  wire ext_mode;
  assign ext_mode = (ctrl_byte_q[`ASI_CTRL_MODE_HI:`ASI_CTRL_MODE_LO] == `ASI_MODE_EXT_CLK);

  // conversion and result shifting
  wire tmr_busy;
  wire tmr_done;
  reg [1:0] cv_q;
  reg [RES_W-1:0] res_sh_q;
  reg [4:0] res_cnt_q;
  reg [9:0] code_q;
  reg [15:0] conv_count_q;
  reg int_start;

  always @* begin
    int_start = conv_go & ~ext_mode;
  end

  asi_conv_timer #(
    .CYCLES(CONV_CYCLES),
    .CW(16)
  ) u_timer (
    .clk(CLK),
    .arst_n(ARST_N),
    .start(int_start),
    .abort(pd_lo_s),
    .busy(tmr_busy),
    .done(tmr_done)
  );

  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cv_q <= CV_IDLE;
      res_sh_q <= {RES_W{1'b0}};
      res_cnt_q <= 5'h00;
      DOUT_O <= 1'b0;
      CONVERSION_STROBE_OUT <= 1'b1;
      conv_count_q <= 16'h0000;
    end else if (pd_lo_s) begin
      cv_q <= CV_IDLE;
      DOUT_O <= 1'b0;
      CONVERSION_STROBE_OUT <= 1'b1;
    end else if (conv_go) begin
      res_sh_q <= code_q[RES_W-1:0];
      if (ext_mode) begin
        cv_q <= CV_STRB;
        CONVERSION_STROBE_OUT <= 1'b1;
      end else begin
        cv_q <= CV_INT;
        CONVERSION_STROBE_OUT <= 1'b0;
      end
    end else begin
      case (cv_q)
        CV_IDLE: begin
          cv_q <= CV_IDLE;
        end
        CV_STRB: begin
          if (cs_n_s) begin
            cv_q <= CV_IDLE;
            CONVERSION_STROBE_OUT <= 1'b0;
          end else if (sclk_fall) begin
            CONVERSION_STROBE_OUT <= 1'b0;
            DOUT_O <= res_sh_q[RES_W-1];
            res_sh_q <= {res_sh_q[RES_W-2:0], 1'b0};
            res_cnt_q <= RES_W[4:0] - 5'h01;
            cv_q <= CV_SHIFT;
          end
        end
        CV_INT: begin
          if (tmr_done) begin
            CONVERSION_STROBE_OUT <= 1'b1;
            res_cnt_q <= RES_W[4:0];
            conv_count_q <= conv_count_q + 16'h0001;
            cv_q <= CV_SHIFT;
          end
        end
        CV_SHIFT: begin
          if (cs_n_s) begin
            cv_q <= CV_IDLE;
            res_cnt_q <= 5'h00;
          end else if (sclk_fall) begin
            if (res_cnt_q != 5'h00) begin
              DOUT_O <= res_sh_q[RES_W-1];
              res_sh_q <= {res_sh_q[RES_W-2:0], 1'b0};
              res_cnt_q <= res_cnt_q - 5'h01;
              if (res_cnt_q == 5'h01 && ext_mode) begin
                conv_count_q <= conv_count_q + 16'h0001;
              end
            end else begin
              DOUT_O <= 1'b0;
              cv_q <= CV_IDLE;
            end
          end
        end
        default: cv_q <= CV_IDLE;
      endcase
    end
  end

  // pin enables and power decode
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      DOUT_OE_N <= 1'b1;
      CONVERSION_STROBE_OUT_OE_N <= 1'b1;
      SHUTDOWN_ACTIVE <= 1'b0;
      REF_INTERNAL_COMP <= 1'b0;
    end else begin
      DOUT_OE_N <= ~link_on;
      if (pd_lo_s) begin
        CONVERSION_STROBE_OUT_OE_N <= 1'b1;
      end else if (ext_mode) begin
        CONVERSION_STROBE_OUT_OE_N <= cs_n_s;
      end else begin
        CONVERSION_STROBE_OUT_OE_N <= 1'b0;
      end
      SHUTDOWN_ACTIVE <= pd_lo_s;
      REF_INTERNAL_COMP <= ~pd_lo_s & pd_hi_s;
    end
  end

  // register bus slave, one wait state per access
  wire req;
  wire [31:0] status_word;
  reg [31:0] rd_mux;

  assign req = (AVS_READ | AVS_WRITE) & AVS_WAITREQUEST;
  assign status_word = {25'h000_0000, ctrl_valid_q, REF_INTERNAL_COMP, SHUTDOWN_ACTIVE,
                        ext_mode, hold_q, track_q, (cv_q != CV_IDLE) | tmr_busy};

  always @* begin
    case (AVS_ADDRESS)
      `ASI_REG_CODE: rd_mux = {22'h00_0000, code_q};
      `ASI_REG_STATUS: rd_mux = status_word;
      `ASI_REG_COUNT: rd_mux = {16'h0000, conv_count_q};
      `ASI_REG_CTRL_BYTE: rd_mux = {24'h00_0000, ctrl_byte_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA <= 32'h0000_0000;
      code_q <= `ASI_CODE_RESET;
    end else begin
      if (req) begin
        AVS_WAITREQUEST <= 1'b0;
        if (AVS_READ) begin
          AVS_READDATA <= rd_mux;
        end
      end else begin
        AVS_WAITREQUEST <= 1'b1;
      end
      // a write lands at the edge where the master sees waitrequest low
      if (AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == `ASI_REG_CODE) begin
        if (AVS_BYTEENABLE[0]) begin
          code_q[7:0] <= AVS_WRITEDATA[7:0];
        end
        if (AVS_BYTEENABLE[1]) begin
          code_q[9:8] <= AVS_WRITEDATA[9:8];
        end
      end
    end
  end

endmodule
`default_nettype wire

// File: verif/asi_sva.sv
`timescale 1ns/1ns
`default_nettype none
module asi_sva #(
  parameter INT_CONV_NS = 10000
) (
  // system
  input wire logic CLK,
  input wire logic ARST_N,
  // link
  input wire logic CS_N,
  input wire logic SCLK,
  input wire logic DIN,
  input wire logic DOUT_O,
  input wire logic DOUT_OE_N,
  input wire logic CONVERSION_STROBE_OUT,
  input wire logic CONVERSION_STROBE_OUT_OE_N,
  // powerdown
  input wire logic THREE_LEVEL_POWERDOWN_IN_LO,
  input wire logic THREE_LEVEL_POWERDOWN_IN_HI,
  input wire logic SHUTDOWN_ACTIVE,
  input wire logic REF_INTERNAL_COMP
);
  logic sclk_q;
  logic [3:0] cnt_q;
  logic md_q;
  logic ext_q;
  wire st = CONVERSION_STROBE_OUT;
  wire st_oe_n = CONVERSION_STROBE_OUT_OE_N;
  wire lo = THREE_LEVEL_POWERDOWN_IN_LO;
  wire hi = THREE_LEVEL_POWERDOWN_IN_HI;
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  // mode of the last control byte, decoded from the pins
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sclk_q <= 1'b0;
      cnt_q <= 4'h0;
      md_q <= 1'b0;
      ext_q <= 1'b0;
    end else begin
      sclk_q <= SCLK;
      if (CS_N) begin
        cnt_q <= 4'h0;
      end else if (SCLK && !sclk_q && (DIN || cnt_q != 4'h0)) begin
        cnt_q <= (cnt_q == 4'h7) ? 4'h0 : cnt_q + 4'h1;
        md_q <= DIN;
        if (cnt_q == 4'h7) begin
          ext_q <= md_q && DIN;
        end
      end
    end
  end
  sequence s_pulse_tail;
    st [*8] ##1 !st;
  endsequence
  AST_DOUT_HIZ: assert property (CS_N [*5] |=> DOUT_OE_N)
    else $error("result line driven while deselected");
  AST_DOUT_EDGE: assert property ($changed(DOUT_O) && !DOUT_OE_N |-> !$past(SCLK, 2))
    else $error("result bit changed outside a clock fall");
  AST_THREE_LEVEL_POWERDOWN_IN: assert property (lo [*5] |=> SHUTDOWN_ACTIVE && DOUT_OE_N && st_oe_n)
    else $error("shutdown not entered");
  AST_REF_INT: assert property ((hi && !lo) [*5] |=> REF_INTERNAL_COMP && !SHUTDOWN_ACTIVE)
    else $error("high level not decoded");
  AST_REF_EXT: assert property ((!hi && !lo) [*5] |=> !REF_INTERNAL_COMP && !SHUTDOWN_ACTIVE)
    else $error("mid level not decoded");
  AST_EXT_PULSE: assert property (ext_q && $rose(st) && !st_oe_n |-> s_pulse_tail)
    else $error("strobe pulse not one serial period");
  AST_INT_LOW: assert property (!ext_q && $fell(st) && !st_oe_n |-> !st [*8])
    else $error("strobe rose before conversion end");
  AST_EXT_HIZ: assert property ((ext_q && CS_N) [*5] |=> st_oe_n)
    else $error("strobe driven while deselected");
endmodule
bind asi_serial_strobe asi_sva #(.INT_CONV_NS(INT_CONV_NS)) i_sva (
  .CLK(CLK), .ARST_N(ARST_N), .CS_N(CS_N), .SCLK(SCLK), .DIN(DIN), .DOUT_O(DOUT_O),
  .DOUT_OE_N(DOUT_OE_N), .CONVERSION_STROBE_OUT(CONVERSION_STROBE_OUT),
  .CONVERSION_STROBE_OUT_OE_N(CONVERSION_STROBE_OUT_OE_N),
  .THREE_LEVEL_POWERDOWN_IN_LO(THREE_LEVEL_POWERDOWN_IN_LO),
  .THREE_LEVEL_POWERDOWN_IN_HI(THREE_LEVEL_POWERDOWN_IN_HI),
  .SHUTDOWN_ACTIVE(SHUTDOWN_ACTIVE), .REF_INTERNAL_COMP(REF_INTERNAL_COMP));
`default_nettype wire

// File: verif/asi_host.sv
`timescale 1ns/1ns
`default_nettype none
module asi_host (
  // clock
  input wire logic clk,
  // link out
  output var logic cs_n,
  output var logic sclk,
  output var logic din,
  // link in
  input wire logic dout,
  input wire logic dout_oe_n,
  input wire logic strb
);
  logic last_q = 1'b0;
  // a released line shows the inverse of its last driven level
  wire dline = dout_oe_n ? ~last_q : dout;
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
  end
  always @(posedge clk) begin
    if (!dout_oe_n) begin
      last_q <= dout;
    end
  end
  // one serial period, 50% duty: fall, data out, sample, rise
  task automatic cyc(input logic b, output logic s);
    sclk <= 1'b0;
    din <= b;
    repeat (4) @(posedge clk);
    s = dline;
    sclk <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  task automatic frame(input logic [7:0] c, output logic [9:0] r, output logic [10:0] sb);
    logic s;
    logic [8:0] w;
    integer i;
    integer t;
    w = {1'b0, c};
    r = 10'h000;
    sb = 11'h000;
    cs_n <= 1'b0;
    repeat (4) @(posedge clk);
    for (i = 8; i >= 0; i--) begin
      cyc(w[i], s);
    end
    if (c[1:0] != 2'h3) begin
      sclk <= 1'b0;
      repeat (8) @(posedge clk);
      t = 0;
      while (strb !== 1'b1 && t < 200) begin
        @(posedge clk);
        t++;
      end
    end
    for (i = 0; i < 11; i++) begin
      cyc(1'b0, s);
      sb = {sb[9:0], strb};
      if (i > 0) begin
        r = {r[8:0], s};
      end
    end
    sclk <= 1'b0;
    repeat (4) @(posedge clk);
    cs_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// File: verif/asi_serial_strobe_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module asi_serial_strobe_tb_top;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic pd_lo = 1'b0;
  logic pd_hi = 1'b0;
  wire cs_n, sclk, din, waitreq, dout, dout_oe_n, strb, strb_oe_n, shut, ref_int;
  wire [31:0] rdata;
  integer n_fail = 0;
  integer checks_done = 0;
  logic [7:0] ctrls [5] = '{8'h80, 8'hF5, 8'hAA, 8'hCB, 8'hFF};
  logic [9:0] codes [5] = '{10'h3FF, 10'h001, 10'h2AA, 10'h200, 10'h155};
  always #5 clk = ~clk;
  asi_serial_strobe #(.INT_CONV_NS(200)) i_dut (
    .CLK(clk), .ARST_N(arst_n), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(waitreq), .CS_N(cs_n), .SCLK(sclk), .DIN(din), .DOUT_O(dout),
    .DOUT_OE_N(dout_oe_n), .CONVERSION_STROBE_OUT(strb),
    .CONVERSION_STROBE_OUT_OE_N(strb_oe_n), .THREE_LEVEL_POWERDOWN_IN_LO(pd_lo),
    .THREE_LEVEL_POWERDOWN_IN_HI(pd_hi), .SHUTDOWN_ACTIVE(shut), .REF_INTERNAL_COMP(ref_int));
  asi_host i_host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout),
    .dout_oe_n(dout_oe_n), .strb(strb));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    do @(posedge clk); while (waitreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    #300000;
    n_fail++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_sim;
  end
  initial begin
    logic [31:0] q;
    logic [9:0] r;
    logic [10:0] sb;
    logic s;
    integer i;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    bus(1'b0, 4'h0, 32'h0000_0000, q);
    chk(q, 32'h0000_0000);
    bus(1'b0, 4'h2, 32'h0000_0000, q);
    chk(q, 32'h0000_0000);
    for (i = 0; i < 5; i++) begin
      bus(1'b1, 4'h0, 32'(codes[i]), q);
      i_host.frame(ctrls[i], r, sb);
      chk(32'(r), 32'(codes[i]));
      chk(32'(sb), (ctrls[i][1:0] == 2'h3) ? 32'h0000_0400 : 32'h0000_07FF);
      chk(32'(dout_oe_n), 32'h0000_0001);
      bus(1'b0, 4'hC, 32'h0000_0000, q);
      chk(q, 32'(ctrls[i]));
      bus(1'b0, 4'h8, 32'h0000_0000, q);
      chk(q, 32'(i + 1));
    end
    for (i = 0; i < 8; i++) begin
      i_host.cyc(i == 0, s);
    end
    bus(1'b0, 4'hC, 32'h0000_0000, q);
    chk(q, 32'(ctrls[4]));
    pd_lo <= 1'b1;
    repeat (8) @(posedge clk);
    chk(32'({shut, ref_int}), 32'h0000_0002);
    bus(1'b0, 4'h4, 32'h0000_0000, q);
    chk(q, 32'h0000_0058);
    i_host.frame(8'hC3, r, sb);
    bus(1'b0, 4'h8, 32'h0000_0000, q);
    chk(q, 32'h0000_0005);
    pd_lo <= 1'b0;
    pd_hi <= 1'b1;
    repeat (8) @(posedge clk);
    chk(32'({shut, ref_int}), 32'h0000_0001);
    pd_hi <= 1'b0;
    repeat (8) @(posedge clk);
    chk(32'({shut, ref_int}), 32'h0000_0000);
    end_sim;
  end
endmodule
`default_nettype wire
